// ==== hdl/cida_core.sv ====
// Conditional instruction decoder and add/and ALU with AXI4-Lite access
// Functional notes
// - Three 32-bit layouts: three-register, two-register-immediate, one-register-immediate
// - Three-register: execution_condition_field 31..28, opcode 27..24, rd 23..19, sources, function 3..0
// - Two-register-immediate: same selectors, 10-bit immediate 13..4, function 3..0
// - One-register-immediate: selector 23..19, 19-bit immediate 18..0; not decoded here, imm19 is only read back at the ID address
// - Condition codes: never, zero, not zero, pz, pos, nz, neg, ovf, novf, always
// - Condition uses current flags; a false condition leaves the register file and flags unchanged, but the program counter still advances
// - Unused bits are don't-care; fixed patterns must match exactly
// - Zero, positive, negative from result; overflow from overflow; else cleared
// - Every executed ALU instruction updates all four flags
// - ALU operation chosen by function field only, regardless of form
// - Three-register add writes 64-bit sum, overflow on signed overflow
// - Immediate add sign-extends the 10-bit immediate, overflow on signed overflow
// - Three-register AND writes bitwise AND of both sources
// - Immediate AND zero-extends the 10-bit immediate
// - Selector zero reads zero; writes to it are dropped
// - Four-bit flag register, read by every instruction, not addressable
// - 19-bit program counter advances by one per completed instruction
`timescale 1ns/10ps
`include "cida_defines.svh"
module cida_core
  import cida_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // Registers visible to software
  // ****************************************
  logic [31:0] instrWord;
  logic [4:0] viewSel;
  logic [3:0] flags;
  logic [63:0] lastResult;
  logic executed;
  logic recognised;
  logic busy;
  logic [18:0] pc;
  logic [31:0] hostData;
  logic startPulse;
  cida_state_t state;
  cida_regfile_if rf();

  // ****************************************
  // Field decode
  // ****************************************
  wire [3:0] execCond = instrWord[`CIDA_EXCOND_HI:`CIDA_EXCOND_LO];
  wire [3:0] opcode = instrWord[`CIDA_OPC_HI:`CIDA_OPC_LO];
  wire [4:0] destSel = instrWord[`CIDA_RD_HI:`CIDA_RD_LO];
  wire [4:0] firstSourceSel = instrWord[`CIDA_SRC1_HI:`CIDA_SRC1_LO];
  wire [4:0] secondSourceSel = instrWord[`CIDA_SRC2_HI:`CIDA_SRC2_LO];
  wire [9:0] imm10 = instrWord[`CIDA_IMM10_HI:`CIDA_IMM10_LO];
  wire [18:0] imm19 = instrWord[`CIDA_IMM19_HI:`CIDA_IMM19_LO];
  wire [3:0] funcField = instrWord[`CIDA_FUNC_HI:`CIDA_FUNC_LO];
  // Only opcode and function are fixed patterns; bits 8..4 of the register form are ignored
  wire cida_fmt_t format = (opcode == `CIDA_OPC_REG) ? CIDA_FMT_THREE_REG :
    (opcode == `CIDA_OPC_IMM) ? CIDA_FMT_TWO_REG_IMM : CIDA_FMT_NONE;
  wire cida_alu_t aluOp = (funcField == `CIDA_FUNC_ADD) ? CIDA_OP_ADD :
    (funcField == `CIDA_FUNC_AND) ? CIDA_OP_AND : CIDA_OP_NONE;
  wire isAlu = (format != CIDA_FMT_NONE) && (aluOp != CIDA_OP_NONE);

  // ****************************************
  // Condition evaluation
  // ****************************************
  logic condMet;
  always_comb
  begin
    case (cida_excond_t'(execCond))
      CIDA_NEVER: condMet = 1'b0;
      CIDA_ZERO: condMet = flags[`CIDA_FLAG_Z];
      CIDA_NZERO: condMet = !flags[`CIDA_FLAG_Z];
      CIDA_PZ: condMet = flags[`CIDA_FLAG_P] || flags[`CIDA_FLAG_Z];
      CIDA_POS: condMet = flags[`CIDA_FLAG_P];
      CIDA_NZ: condMet = flags[`CIDA_FLAG_N] || flags[`CIDA_FLAG_Z];
      CIDA_NEG: condMet = flags[`CIDA_FLAG_N];
      CIDA_OVF: condMet = flags[`CIDA_FLAG_V];
      CIDA_NOVF: condMet = !flags[`CIDA_FLAG_V];
      CIDA_ALWAYS: condMet = 1'b1;
      default: condMet = 1'b0;
    endcase
  end

  // ****************************************
  // ALU
  // ****************************************
  wire [63:0] srcA = rf.rdDataA;
  // Sign extension for add, zero extension for and
  wire [63:0] immExt = (aluOp == CIDA_OP_ADD) ? {{54{imm10[9]}}, imm10} : {54'h0, imm10};
  wire [63:0] srcB = (format == CIDA_FMT_THREE_REG) ? rf.rdDataB : immExt;
  wire [63:0] sum = srcA + srcB;
  wire sumOvf = (srcA[63] == srcB[63]) && (sum[63] != srcA[63]);
  wire [63:0] conj = srcA & srcB;
  wire [63:0] aluResult = (aluOp == CIDA_OP_ADD) ? sum : conj;
  wire aluOvf = (aluOp == CIDA_OP_ADD) && sumOvf;
  wire [3:0] next_flags = {aluOvf, aluResult[63], !aluResult[63] && |aluResult,
    ~|aluResult};
  wire doExec = (state == CIDA_EXEC) && isAlu && condMet;

  assign rf.rdSelA = firstSourceSel;
  assign rf.rdSelB = secondSourceSel;
  assign rf.wrEn = doExec;
  assign rf.wrSel = destSel;
  assign rf.wrData = aluResult;

  cida_regfile uRegs (.mclk(mclk), .reset(reset), .rf(rf));
  cida_pc_step #(.PC_WIDTH(19)) uPc (.mclk(mclk), .reset(reset),
    .done(state == CIDA_EXEC), .pc(pc));

  // ****************************************
  // Execution sequencing
  // ****************************************
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state <= CIDA_IDLE;
    else
    begin
      case (state)
        CIDA_IDLE: if (startPulse) state <= CIDA_EXEC;
        CIDA_EXEC: state <= CIDA_IDLE;
        default: state <= CIDA_IDLE;
      endcase
    end
  end

  // Flags are internal; software may only observe them
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      flags <= `CIDA_FLAGS_RESET;
    else if (doExec)
      flags <= next_flags;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      lastResult <= 64'h0000000000000000;
      executed <= 1'b0;
      recognised <= 1'b0;
    end
    else if (state == CIDA_EXEC)
    begin
      lastResult <= doExec ? aluResult : lastResult;
      executed <= doExec;
      recognised <= isAlu;
    end
  end
  assign busy = (state != CIDA_IDLE);

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic awHeld;
  logic wHeld;
  logic [31:0] awAddr;
  logic [31:0] wData;
  wire wrFire = awHeld && wHeld && !s_axi_bvalid;
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;
  // Full address compare, so aliases above the map answer with an error
  wire wrCtrl = wrFire && awAddr == `CIDA_ADDR_REG_CTRL;
  wire wrInstr = wrFire && awAddr == `CIDA_ADDR_REG_INSTR;
  wire wrSelReg = wrFire && awAddr == `CIDA_ADDR_REG_SEL;
  wire wrOk = wrCtrl || wrInstr || wrSelReg;
  assign startPulse = wrCtrl && wData[0] && !busy;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 32'h00000000;
      wData <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
      end
      if (wrFire)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Full-word writes only; partial strobes still load the whole word
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      instrWord <= 32'h00000000;
      viewSel <= 5'h00;
    end
    else
    begin
      if (wrInstr && !busy)
        instrWord <= wData;
      if (wrSelReg)
        viewSel <= wData[4:0];
    end
  end

  always_comb
  begin
    hostData = 32'h00000000;
    case (s_axi_araddr)
      `CIDA_ADDR_REG_STATUS: hostData = {25'h0, recognised, executed, busy, flags};
      `CIDA_ADDR_REG_INSTR: hostData = instrWord;
      `CIDA_ADDR_REG_SEL: hostData = {27'h0, viewSel};
      `CIDA_ADDR_REG_DLO: hostData = lastResult[31:0];
      `CIDA_ADDR_REG_DHI: hostData = lastResult[63:32];
      `CIDA_ADDR_REG_PC: hostData = {13'h0, pc};
      `CIDA_ADDR_REG_ID: hostData = {13'h0, imm19};
      default: hostData = 32'h00000000;
    endcase
  end
  wire rdOk = (s_axi_araddr[7:0] <= 8'h1C) && (s_axi_araddr[7:0] != 8'h00) &&
    (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[31:8] == 24'h0);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdOk ? hostData : 32'h00000000;
      s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence sExecFalse;
    state == CIDA_EXEC && !condMet;
  endsequence
  AST_FALSE_NO_EFFECT: assert property (@(posedge mclk) disable iff (reset)
    sExecFalse |-> !rf.wrEn ##1 $stable(flags))
    else $error("False condition changed state");
  AST_RESERVED_NEVER: assert property (@(posedge mclk) disable iff (reset)
    execCond inside {[4'h9:4'hE]} |-> !condMet)
    else $error("Reserved condition executed");
  AST_ALWAYS: assert property (@(posedge mclk) disable iff (reset)
    execCond == 4'hF |-> condMet)
    else $error("Always condition not met");
  AST_FLAG_ZERO: assert property (@(posedge mclk) disable iff (reset)
    doExec |=> flags[`CIDA_FLAG_Z] == ($past(aluResult) == 64'h0))
    else $error("Zero flag wrong");
  AST_FLAG_ONEHOT: assert property (@(posedge mclk) disable iff (reset)
    $past(doExec) |-> $onehot(flags[2:0]))
    else $error("Sign flags not exclusive");
  AST_ADD_SUM: assert property (@(posedge mclk) disable iff (reset)
    doExec && aluOp == CIDA_OP_ADD && format == CIDA_FMT_THREE_REG
      |-> rf.wrData == rf.rdDataA + rf.rdDataB)
    else $error("Add result wrong");
  AST_AND_IMM_ZEXT: assert property (@(posedge mclk) disable iff (reset)
    doExec && aluOp == CIDA_OP_AND && format == CIDA_FMT_TWO_REG_IMM
      |-> rf.wrData[63:10] == 54'h0)
    else $error("Immediate AND not zero-extended");
  AST_ADD_IMM_OVF: assert property (@(posedge mclk) disable iff (reset)
    doExec && aluOp == CIDA_OP_ADD && format == CIDA_FMT_TWO_REG_IMM
      && srcA == 64'h7FFFFFFFFFFFFFFF
      && imm10 == 10'h001 |=> flags[`CIDA_FLAG_V])
    else $error("Immediate add overflow missed");
endmodule : cida_core

// ==== hdl/cida_defines.svh ====
// Constants for the conditional instruction decoder and ALU
`ifndef CIDA_DEFINES_SVH
`define CIDA_DEFINES_SVH
`define CIDA_EXCOND_HI 31
`define CIDA_EXCOND_LO 28
`define CIDA_OPC_HI 27
`define CIDA_OPC_LO 24
`define CIDA_RD_HI 23
`define CIDA_RD_LO 19
`define CIDA_SRC1_HI 18
`define CIDA_SRC1_LO 14
`define CIDA_SRC2_HI 13
`define CIDA_SRC2_LO 9
`define CIDA_IMM10_HI 13
`define CIDA_IMM10_LO 4
`define CIDA_IMM19_HI 18
`define CIDA_IMM19_LO 0
`define CIDA_FUNC_HI 3
`define CIDA_FUNC_LO 0
`define CIDA_OPC_REG 4'h8
`define CIDA_OPC_IMM 4'hC
`define CIDA_FUNC_ADD 4'h0
`define CIDA_FUNC_AND 4'h5
`define CIDA_FLAG_Z 0
`define CIDA_FLAG_P 1
`define CIDA_FLAG_N 2
`define CIDA_FLAG_V 3
`define CIDA_FLAGS_RESET 4'h0
`define CIDA_PC_RESET 19'h00000
`define CIDA_PC_STEP 19'h00001
`define CIDA_ADDR_REG_CTRL 32'h00000000
`define CIDA_ADDR_REG_STATUS 32'h00000004
`define CIDA_ADDR_REG_INSTR 32'h00000008
`define CIDA_ADDR_REG_SEL 32'h0000000C
`define CIDA_ADDR_REG_DLO 32'h00000010
`define CIDA_ADDR_REG_DHI 32'h00000014
`define CIDA_ADDR_REG_PC 32'h00000018
`define CIDA_ADDR_REG_ID 32'h0000001C
`endif

// ==== hdl/cida_pc_step.sv ====
// Program counter that advances once per completed instruction
`timescale 1ns/10ps
`include "cida_defines.svh"
module cida_pc_step
  import cida_pkg::*;
#(
  parameter int PC_WIDTH = 19
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic done,
  output logic [PC_WIDTH-1:0] pc
);
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pc <= PC_WIDTH'(`CIDA_PC_RESET);
    else if (done)
      pc <= pc + PC_WIDTH'(`CIDA_PC_STEP);
  end

  AST_PC_ADVANCE: assert property (@(posedge mclk) disable iff (reset)
    done |=> pc == $past(pc) + PC_WIDTH'(1))
    else $error("Program counter did not advance by one");
  AST_PC_HOLD: assert property (@(posedge mclk) disable iff (reset)
    !done |=> $stable(pc))
    else $error("Program counter moved without an instruction");
endmodule : cida_pc_step

// ==== hdl/cida_pkg.sv ====
// Types for the conditional instruction decoder and ALU
package cida_pkg;
  typedef enum logic [3:0] {
    CIDA_NEVER = 4'h0, CIDA_ZERO = 4'h1, CIDA_NZERO = 4'h2, CIDA_PZ = 4'h3,
    CIDA_POS = 4'h4, CIDA_NZ = 4'h5, CIDA_NEG = 4'h6, CIDA_OVF = 4'h7,
    CIDA_NOVF = 4'h8, CIDA_ALWAYS = 4'hF
  } cida_excond_t;
  typedef enum logic [1:0] {
    CIDA_FMT_THREE_REG, CIDA_FMT_TWO_REG_IMM, CIDA_FMT_ONE_REG_IMM, CIDA_FMT_NONE
  } cida_fmt_t;
  typedef enum logic [1:0] {CIDA_OP_ADD, CIDA_OP_AND, CIDA_OP_NONE} cida_alu_t;
  typedef enum {CIDA_IDLE, CIDA_EXEC} cida_state_t;
endpackage : cida_pkg

// ==== hdl/cida_regfile.sv ====
// Thirty-one general registers plus the hard-wired zero register
`timescale 1ns/10ps
`include "cida_defines.svh"
module cida_regfile
  import cida_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  cida_regfile_if.store rf
);
  logic [63:0] regs [1:31];
  genvar gi;
  generate
    for (gi = 1; gi < 32; gi = gi + 1)
    begin : gReg
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
          regs[gi] <= 64'h0000000000000000;
        else if (rf.wrEn && rf.wrSel == 5'(gi))
          regs[gi] <= rf.wrData;
      end
    end
  endgenerate
  // Writes to selector zero simply fall through
  assign rf.rdDataA = (rf.rdSelA == 5'h00) ? 64'h0000000000000000 : regs[rf.rdSelA];
  assign rf.rdDataB = (rf.rdSelB == 5'h00) ? 64'h0000000000000000 : regs[rf.rdSelB];

  AST_ZERO_READS_ZERO: assert property (@(posedge mclk) disable iff (reset)
    rf.rdSelA == 5'h00 |-> rf.rdDataA == 64'h0000000000000000)
    else $error("Zero register read non-zero");
endmodule : cida_regfile

// ==== hdl/cida_regfile_if.sv ====
// Register file access bundle between the core and its register file
`timescale 1ns/10ps
interface cida_regfile_if;
  logic [4:0] rdSelA;
  logic [4:0] rdSelB;
  logic [63:0] rdDataA;
  logic [63:0] rdDataB;
  logic wrEn;
  logic [4:0] wrSel;
  logic [63:0] wrData;
  modport core (output rdSelA, rdSelB, wrEn, wrSel, wrData, input rdDataA, rdDataB);
  modport store (input rdSelA, rdSelB, wrEn, wrSel, wrData, output rdDataA, rdDataB);
endinterface : cida_regfile_if

// ==== verification/cida_axi_master.sv ====
// Bus master model standing in for host software on the register port
`timescale 1ns/10ps
module cida_axi_master
(
  input wire logic mclk,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ********************
  // Write and read cycles
  // ********************
  initial
  begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hF;
  end
  // Released lines carry the inverse, so a stale value never passes for a live one
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axiWrite
  task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axiRead
endmodule : cida_axi_master

// ==== verification/tb.sv ====
// Self-checking bench for the conditional decoder core
`timescale 1ns/10ps
`include "cida_defines.svh"
module tb;
  // ********************
  // Clock, reset, wiring
  // ********************
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures = 0;
  int check_count = 0;
  int pcCount = 0;
  always #20 mclk = ~mclk;
  cida_core cida_core_inst (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  cida_axi_master cida_axi_master_inst (.mclk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ********************
  // Helpers
  // ********************
  task automatic chkData(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chkData
  task automatic chkResp(input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: resp expected %h got %h", $time, exp, got);
    end
  endtask : chkResp
  function automatic logic [31:0] immWord(logic [3:0] c, logic [4:0] d, logic [4:0] s,
    logic [9:0] k, logic [3:0] f);
    return {c, `CIDA_OPC_IMM, d, s, k, f};
  endfunction : immWord
  // Unused middle bits are set on purpose: they must not matter
  function automatic logic [31:0] regWord(logic [3:0] c, logic [4:0] d, logic [4:0] s,
    logic [4:0] t, logic [3:0] f);
    return {c, `CIDA_OPC_REG, d, s, t, 5'h15, f};
  endfunction : regWord
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    cida_axi_master_inst.axiWrite(a, d, r);
    chkResp(er, r);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er,
    input logic [31:0] mask);
    logic [31:0] d;
    logic [1:0] r;
    cida_axi_master_inst.axiRead(a, d, r);
    chkResp(er, r);
    chkData(exp, d & mask);
  endtask : rdc
  task automatic run(input logic [31:0] instr);
    wr(`CIDA_ADDR_REG_INSTR, instr, 2'h0);
    wr(`CIDA_ADDR_REG_CTRL, 32'h1, 2'h0);
    pcCount++;
  endtask : run
  task automatic stat(input logic [31:0] exp, input logic [31:0] mask);
    rdc(`CIDA_ADDR_REG_STATUS, exp, 2'h0, mask);
  endtask : stat
  task automatic res(input logic [31:0] lo, input logic [31:0] hi);
    rdc(`CIDA_ADDR_REG_DLO, lo, 2'h0, 32'hFFFFFFFF);
    rdc(`CIDA_ADDR_REG_DHI, hi, 2'h0, 32'hFFFFFFFF);
  endtask : res
  // ********************
  // Scenarios
  // ********************
  task automatic testReset();
    stat(32'h0, 32'hFFFFFFFF);
    rdc(`CIDA_ADDR_REG_PC, 32'h0, 2'h0, 32'hFFFFFFFF);
  endtask : testReset
  task automatic testAddImm();
    run(immWord(4'hF, 5'h1, 5'h0, 10'h005, `CIDA_FUNC_ADD));
    res(32'h5, 32'h0);
    stat(32'h62, 32'hFF);
    run(immWord(4'hF, 5'h2, 5'h0, 10'h3FF, `CIDA_FUNC_ADD));
    res(32'hFFFFFFFF, 32'hFFFFFFFF);
    stat(32'h64, 32'hFF);
  endtask : testAddImm
  task automatic testAnd();
    run(immWord(4'hF, 5'h3, 5'h2, 10'h3FF, `CIDA_FUNC_AND));
    res(32'h3FF, 32'h0);
    stat(32'h62, 32'hFF);
    run(regWord(4'hF, 5'h4, 5'h1, 5'h3, `CIDA_FUNC_AND));
    res(32'h5, 32'h0);
    run(regWord(4'hF, 5'h5, 5'h2, 5'h1, `CIDA_FUNC_ADD));
    res(32'h4, 32'h0);
    stat(32'h62, 32'hFF);
  endtask : testAnd
  task automatic testOverflow();
    run(immWord(4'hF, 5'h6, 5'h0, 10'h001, `CIDA_FUNC_ADD));
    repeat (63) run(regWord(4'hF, 5'h6, 5'h6, 5'h6, `CIDA_FUNC_ADD));
    res(32'h0, 32'h80000000);
    stat(32'h6C, 32'hFF);
    run(regWord(4'hF, 5'h9, 5'h6, 5'h6, `CIDA_FUNC_AND));
    stat(32'h64, 32'hFF);
    // Most negative plus minus one, then most positive plus one: both overflow
    run(immWord(4'hF, 5'hB, 5'h6, 10'h3FF, `CIDA_FUNC_ADD));
    res(32'hFFFFFFFF, 32'h7FFFFFFF);
    stat(32'h6A, 32'hFF);
    run(immWord(4'hF, 5'hC, 5'hB, 10'h001, `CIDA_FUNC_ADD));
    res(32'h0, 32'h80000000);
    stat(32'h6C, 32'hFF);
  endtask : testOverflow
  task automatic testZeroReg();
    run(immWord(4'hF, 5'h0, 5'h0, 10'h007, `CIDA_FUNC_ADD));
    run(immWord(4'hF, 5'h8, 5'h0, 10'h000, `CIDA_FUNC_ADD));
    res(32'h0, 32'h0);
    stat(32'h61, 32'hFF);
  endtask : testZeroReg
  task automatic testCond();
    logic [31:0] prep [4];
    logic [15:0] mask [4];
    logic [3:0] fl [4];
    prep[0] = immWord(4'hF, 5'h2, 5'h0, 10'h3FF, `CIDA_FUNC_ADD);
    prep[1] = immWord(4'hF, 5'h2, 5'h0, 10'h000, `CIDA_FUNC_ADD);
    prep[2] = immWord(4'hF, 5'h2, 5'h0, 10'h001, `CIDA_FUNC_ADD);
    prep[3] = regWord(4'hF, 5'hA, 5'h6, 5'h6, `CIDA_FUNC_ADD);
    mask = '{16'h8164, 16'h812A, 16'h811C, 16'h80AA};
    fl = '{4'h4, 4'h1, 4'h2, 4'h9};
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 16; c++)
      begin
        run(prep[s]);
        run(immWord(4'(c), 5'h7, 5'h0, 10'h001, `CIDA_FUNC_ADD));
        stat(mask[s][c] ? 32'h22 : {28'h0, fl[s]}, 32'h2F);
      end
  endtask : testCond
  task automatic testUnrec();
    run(immWord(4'hF, 5'h2, 5'h0, 10'h3FF, `CIDA_FUNC_ADD));
    run(32'hF9000000);
    stat(32'h04, 32'h4F);
    run(regWord(4'hF, 5'h7, 5'h0, 5'h0, 4'h1));
    stat(32'h04, 32'h4F);
  endtask : testUnrec
  task automatic testBus();
    rdc(32'h20, 32'h0, 2'h2, 32'hFFFFFFFF);
    wr(32'h20, 32'h1, 2'h2);
    rdc(`CIDA_ADDR_REG_CTRL, 32'h0, 2'h2, 32'hFFFFFFFF);
    wr(`CIDA_ADDR_REG_SEL, 32'h3F, 2'h0);
    rdc(`CIDA_ADDR_REG_SEL, 32'h1F, 2'h0, 32'hFFFFFFFF);
    wr(`CIDA_ADDR_REG_INSTR, 32'hFFFFFFFF, 2'h0);
    rdc(`CIDA_ADDR_REG_INSTR, 32'hFFFFFFFF, 2'h0, 32'hFFFFFFFF);
    rdc(`CIDA_ADDR_REG_ID, 32'h7FFFF, 2'h0, 32'hFFFFFFFF);
    rdc(`CIDA_ADDR_REG_PC, 32'(pcCount), 2'h0, 32'hFFFFFFFF);
  endtask : testBus
  // ********************
  // Sequence and verdict
  // ********************
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    testReset();
    testAddImm();
    testAnd();
    testOverflow();
    testZeroReg();
    testCond();
    testUnrec();
    testBus();
    final_report();
  end
  // Whole run needs a few thousand cycles; this leaves ample margin
  initial
  begin
    repeat (30000) @(posedge mclk);
    failures++;
    final_report();
  end
endmodule : tb
